/* logic/aol_pkg.sv */
package aol_pkg;

  localparam int unsigned NUM_LINES = 4;
  localparam int unsigned NUM_MF    = 3;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned TOT_W     = 26;
  localparam int unsigned SEL_W     = 2;

  // Multifunction channel order within a slot
  localparam int unsigned MF_LO  = 0;
  localparam int unsigned MF_HI  = 1;
  localparam int unsigned MF_TOT = 2;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_CLEAR   = 8'h04;
  localparam logic [7:0] OFS_ROUTE   = 8'h08;
  localparam logic [7:0] OFS_MFCFG   = 8'h0C;
  localparam logic [7:0] OFS_PAT_LO  = 8'h10;
  localparam logic [7:0] OFS_PAT_HI  = 8'h14;
  localparam logic [7:0] OFS_TOT_LIM = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1C;

  // Control register fields
  localparam int unsigned CTRL_LATCH = 0;
  localparam int unsigned CTRL_POL   = 1;
  localparam int unsigned CTRL_FRST  = 8;

  // Clear register fields: bits 3..0 select lines, bit 4 clears all
  localparam int unsigned CLR_LINE = 0;
  localparam int unsigned CLR_ALL  = 4;

  // Multifunction config fields
  localparam int unsigned MF_SEL  = 0;
  localparam int unsigned MF_EN   = 8;
  localparam int unsigned MF_DIFF = 12;

  // Pattern register fields
  localparam int unsigned PAT_VAL  = 0;
  localparam int unsigned PAT_CARE = 8;

  // Status register fields
  localparam int unsigned STS_LINE = 0;
  localparam int unsigned STS_MF   = 4;

  // Reset values
  localparam logic              RST_LATCH = 1'b1;
  localparam logic              RST_POL   = 1'b0;
  localparam logic [PORT_W-1:0] RST_CARE  = 8'hFF;
  localparam logic [PORT_W-1:0] RST_VAL   = 8'h00;
  localparam logic [TOT_W-1:0]  RST_LIM   = 26'h0000000;

endpackage

/* logic/aol_alarm_lines.sv */
`timescale 1ns/1ns
// Functional notes
// - Four alarm lines, each the OR of all channels routed to it.
// - Any number of channels may share one line number.
// - One latch/track mode bit governs all four lines.
// - Factory reset deasserts all lines; event outputs are not cleared.
// - Latch mode: line sets on first alarm, holds until clear, scan start, power.
// - Manual clear works at any time, never touches reading memory data.
// - Track mode: line asserted only while a source is outside its limit.
// - Track mode: line drops by itself when the source returns inside.
// - Starting a scan deasserts all alarm lines.
// - Shared polarity: active-low drives 0 on alarm, active-high drives 1.
// - Factory reset returns polarity to active-low.
// - New polarity applies at once to the present alarm state.
// - Port and totalizer alarms evaluated continuously once enabled.
// - Port and totalizer results go to reading memory only during a scan.
// - Scan start clears reading memory but not the queued alarm events.
// - Channel order: lower port first, upper port second, totalizer third.
// - Equal mode fires on masked equality, differ mode on masked inequality.
// - Care bits at zero exclude port bits from the compare.
// - Totalizer alarm fires when count reaches its high limit, on its line.
// - Compare is (data XOR value) AND care; nonzero means different.
module aol_alarm_lines #(
  parameter int unsigned N_EXT = 8
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic [N_EXT-1:0]           ext_alarm_i,
  input  wire logic [aol_pkg::PORT_W-1:0] dio_lo_i,
  input  wire logic [aol_pkg::PORT_W-1:0] dio_hi_i,
  input  wire logic [aol_pkg::TOT_W-1:0]  tot_count_i,
  input  wire logic                       scan_start_i,
  input  wire logic                       scan_active_i,
  output logic [aol_pkg::NUM_LINES-1:0]   alarm_line_o,
  output logic                            evt_valid_o,
  output logic [aol_pkg::NUM_MF-1:0]      evt_flags_o,
  output logic                            rec_valid_o,
  output logic [aol_pkg::NUM_MF-1:0]      rec_flags_o,
  output logic                            mem_clear_o
);

  localparam int unsigned RW = aol_pkg::SEL_W * N_EXT;

  typedef struct packed {
    logic                                   latch;
    logic                                   pol_high;
    logic [RW-1:0]                          route;
    logic [aol_pkg::SEL_W*aol_pkg::NUM_MF-1:0] mf_sel;
    logic [aol_pkg::NUM_MF-1:0]             mf_en;
    logic [1:0]                             mf_diff;
    logic [aol_pkg::PORT_W-1:0]             val_lo;
    logic [aol_pkg::PORT_W-1:0]             care_lo;
    logic [aol_pkg::PORT_W-1:0]             val_hi;
    logic [aol_pkg::PORT_W-1:0]             care_hi;
    logic [aol_pkg::TOT_W-1:0]              tot_lim;
    logic [aol_pkg::PORT_W-1:0]             lo_s1;
    logic [aol_pkg::PORT_W-1:0]             lo_s2;
    logic [aol_pkg::PORT_W-1:0]             hi_s1;
    logic [aol_pkg::PORT_W-1:0]             hi_s2;
    logic [N_EXT-1:0]                       ext_prev;
    logic [aol_pkg::NUM_MF-1:0]             mf_prev;
    logic [aol_pkg::NUM_LINES-1:0]          line;
    logic [aol_pkg::NUM_LINES-1:0]          out;
    logic                                   pready;
    logic                                   pslverr;
    logic [31:0]                            prdata;
    logic                                   evt_valid;
    logic [aol_pkg::NUM_MF-1:0]             evt_flags;
    logic                                   rec_valid;
    logic [aol_pkg::NUM_MF-1:0]             rec_flags;
    logic                                   mem_clear;
  } aol_state_t;

  // Idle active-low lines drive high, hence out starts at all ones
  localparam aol_state_t RST_STATE = '{
    latch    : aol_pkg::RST_LATCH,
    pol_high : aol_pkg::RST_POL,
    val_lo   : aol_pkg::RST_VAL,
    val_hi   : aol_pkg::RST_VAL,
    care_lo  : aol_pkg::RST_CARE,
    care_hi  : aol_pkg::RST_CARE,
    tot_lim  : aol_pkg::RST_LIM,
    out      : '1,
    default  : '0
  };

  aol_state_t st_r;
  aol_state_t st_nxt;

  function automatic logic pat_alarm(
    input logic [aol_pkg::PORT_W-1:0] data,
    input logic [aol_pkg::PORT_W-1:0] value,
    input logic [aol_pkg::PORT_W-1:0] care,
    input logic                       differ
  );
    logic [aol_pkg::PORT_W-1:0] diff_bits;
    logic                       same;
    // A care bit at zero drops that port bit from the compare
    diff_bits = (data ^ value) & care;
    same      = diff_bits == '0;
    return differ ? ~same : same;
  endfunction

  // Mapped word offsets; anything else, misaligned too, is refused with pslverr
  function automatic logic reg_hit(input logic [7:0] addr);
    logic hit;
    unique case (addr)
      aol_pkg::OFS_CTRL,
      aol_pkg::OFS_CLEAR,
      aol_pkg::OFS_ROUTE,
      aol_pkg::OFS_MFCFG,
      aol_pkg::OFS_PAT_LO,
      aol_pkg::OFS_PAT_HI,
      aol_pkg::OFS_TOT_LIM,
      aol_pkg::OFS_STATUS:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic [aol_pkg::NUM_MF-1:0]    mf_alm;
  logic [aol_pkg::NUM_MF-1:0]    mf_rise;
  logic [N_EXT-1:0]              ext_rise;
  logic [aol_pkg::NUM_LINES-1:0] line_lvl;
  logic [aol_pkg::NUM_LINES-1:0] line_rise;
  logic [aol_pkg::NUM_LINES-1:0] clr;
  logic [31:0]                   rd_word;
  logic                          take;
  logic                          wr;
  logic                          frst;

  always_comb
  begin
    st_nxt = st_r;

    // Port pins come from outside, two stages before any compare
    st_nxt.lo_s1 = dio_lo_i;
    st_nxt.lo_s2 = st_r.lo_s1;
    st_nxt.hi_s1 = dio_hi_i;
    st_nxt.hi_s2 = st_r.hi_s1;

    // Evaluated every cycle, independent of scanning
    mf_alm[aol_pkg::MF_LO] = st_r.mf_en[aol_pkg::MF_LO] &
      pat_alarm(st_r.lo_s2, st_r.val_lo, st_r.care_lo, st_r.mf_diff[0]);
    mf_alm[aol_pkg::MF_HI] = st_r.mf_en[aol_pkg::MF_HI] &
      pat_alarm(st_r.hi_s2, st_r.val_hi, st_r.care_hi, st_r.mf_diff[1]);
    mf_alm[aol_pkg::MF_TOT] = st_r.mf_en[aol_pkg::MF_TOT] &
      (tot_count_i >= st_r.tot_lim);
    mf_rise  = mf_alm & ~st_r.mf_prev;
    ext_rise = ext_alarm_i & ~st_r.ext_prev;
    st_nxt.mf_prev  = mf_alm;
    st_nxt.ext_prev = ext_alarm_i;

    // Each source names exactly one line; a line ORs every source naming it
    line_lvl  = '0;
    line_rise = '0;
    for (int i = 0; i < int'(N_EXT); i++)
    begin
      line_lvl[st_r.route[aol_pkg::SEL_W*i +: aol_pkg::SEL_W]]  |= ext_alarm_i[i];
      line_rise[st_r.route[aol_pkg::SEL_W*i +: aol_pkg::SEL_W]] |= ext_rise[i];
    end
    for (int j = 0; j < int'(aol_pkg::NUM_MF); j++)
    begin
      line_lvl[st_r.mf_sel[aol_pkg::SEL_W*j +: aol_pkg::SEL_W]]  |= mf_alm[j];
      line_rise[st_r.mf_sel[aol_pkg::SEL_W*j +: aol_pkg::SEL_W]] |= mf_rise[j];
    end

    // APB: one wait state, writes land on the completing edge
    take = psel_i & penable_i & st_r.pready;
    wr   = take & pwrite_i & reg_hit(paddr_i);
    st_nxt.pready = psel_i & penable_i & ~st_r.pready;

    // Read word decoded from the live address, captured together with pready
    rd_word = '0;
    unique case (paddr_i)
      aol_pkg::OFS_CTRL:
      begin
        rd_word[aol_pkg::CTRL_LATCH] = st_r.latch;
        rd_word[aol_pkg::CTRL_POL]   = st_r.pol_high;
      end
      aol_pkg::OFS_ROUTE:
      begin
        rd_word = 32'(st_r.route);
      end
      aol_pkg::OFS_MFCFG:
      begin
        rd_word[aol_pkg::MF_SEL +: aol_pkg::SEL_W*aol_pkg::NUM_MF] = st_r.mf_sel;
        rd_word[aol_pkg::MF_EN +: aol_pkg::NUM_MF] = st_r.mf_en;
        rd_word[aol_pkg::MF_DIFF +: 2] = st_r.mf_diff;
      end
      aol_pkg::OFS_PAT_LO:
      begin
        rd_word[aol_pkg::PAT_VAL +: aol_pkg::PORT_W]  = st_r.val_lo;
        rd_word[aol_pkg::PAT_CARE +: aol_pkg::PORT_W] = st_r.care_lo;
      end
      aol_pkg::OFS_PAT_HI:
      begin
        rd_word[aol_pkg::PAT_VAL +: aol_pkg::PORT_W]  = st_r.val_hi;
        rd_word[aol_pkg::PAT_CARE +: aol_pkg::PORT_W] = st_r.care_hi;
      end
      aol_pkg::OFS_TOT_LIM:
      begin
        rd_word = 32'(st_r.tot_lim);
      end
      aol_pkg::OFS_STATUS:
      begin
        rd_word[aol_pkg::STS_LINE +: aol_pkg::NUM_LINES] = st_r.line;
        rd_word[aol_pkg::STS_MF +: aol_pkg::NUM_MF]      = st_r.mf_prev;
      end
      default:
      begin
        rd_word = '0;
      end
    endcase
    if (st_nxt.pready)
    begin
      st_nxt.prdata  = pwrite_i ? 32'h00000000 : rd_word;
      st_nxt.pslverr = ~reg_hit(paddr_i);
    end
    else
    begin
      st_nxt.pslverr = 1'b0;
    end

    frst = 1'b0;
    clr  = '0;
    if (wr)
    begin
      unique case (paddr_i)
        aol_pkg::OFS_CTRL:
        begin
          st_nxt.latch    = pwdata_i[aol_pkg::CTRL_LATCH];
          st_nxt.pol_high = pwdata_i[aol_pkg::CTRL_POL];
          frst            = pwdata_i[aol_pkg::CTRL_FRST];
        end
        aol_pkg::OFS_CLEAR:
        begin
          // Write-only strobe: acts for one cycle and reads back zero
          clr = pwdata_i[aol_pkg::CLR_LINE +: aol_pkg::NUM_LINES] |
                {aol_pkg::NUM_LINES{pwdata_i[aol_pkg::CLR_ALL]}};
        end
        aol_pkg::OFS_ROUTE:
        begin
          st_nxt.route = pwdata_i[RW-1:0];
        end
        aol_pkg::OFS_MFCFG:
        begin
          st_nxt.mf_sel  = pwdata_i[aol_pkg::MF_SEL +: aol_pkg::SEL_W*aol_pkg::NUM_MF];
          st_nxt.mf_en   = pwdata_i[aol_pkg::MF_EN +: aol_pkg::NUM_MF];
          st_nxt.mf_diff = pwdata_i[aol_pkg::MF_DIFF +: 2];
        end
        aol_pkg::OFS_PAT_LO:
        begin
          st_nxt.val_lo  = pwdata_i[aol_pkg::PAT_VAL +: aol_pkg::PORT_W];
          st_nxt.care_lo = pwdata_i[aol_pkg::PAT_CARE +: aol_pkg::PORT_W];
        end
        aol_pkg::OFS_PAT_HI:
        begin
          st_nxt.val_hi  = pwdata_i[aol_pkg::PAT_VAL +: aol_pkg::PORT_W];
          st_nxt.care_hi = pwdata_i[aol_pkg::PAT_CARE +: aol_pkg::PORT_W];
        end
        aol_pkg::OFS_TOT_LIM:
        begin
          // Raw count compare: a count that rolls over past the top ends the alarm
          st_nxt.tot_lim = pwdata_i[aol_pkg::TOT_W-1:0];
        end
        default:
        begin
        end
      endcase
    end

    // Factory reset disables port and totalizer alarms and clears the lines but leaves event outputs alone
    if (frst)
    begin
      st_nxt.pol_high = aol_pkg::RST_POL;
      st_nxt.mf_en    = '0;
    end
    if (frst | scan_start_i)
    begin
      clr = '1;
    end

    // A crossing in the clear cycle still sets the latch
    // Track lines follow the OR level; a clear only masks them for one cycle
    if (st_r.latch)
    begin
      st_nxt.line = (st_r.line & ~clr) | line_rise;
    end
    else
    begin
      st_nxt.line = line_lvl & ~clr;
    end

    // Pin follows the new polarity on the same edge that lands the write
    st_nxt.out = st_nxt.pol_high ? st_nxt.line : ~st_nxt.line;

    // Queue events are raised regardless of scan; memory only while scanning
    st_nxt.evt_valid = |mf_rise;
    st_nxt.evt_flags = mf_rise;
    st_nxt.rec_valid = (|mf_rise) & scan_active_i;
    st_nxt.rec_flags = mf_rise & {aol_pkg::NUM_MF{scan_active_i}};
    st_nxt.mem_clear = scan_start_i;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= RST_STATE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata_o     = st_r.prdata;
  assign pready_o     = st_r.pready;
  assign pslverr_o    = st_r.pslverr;
  assign alarm_line_o = st_r.out;
  assign evt_valid_o  = st_r.evt_valid;
  assign evt_flags_o  = st_r.evt_flags;
  assign rec_valid_o  = st_r.rec_valid;
  assign rec_flags_o  = st_r.rec_flags;
  assign mem_clear_o  = st_r.mem_clear;

endmodule

/* bench/aol_alarm_lines_checker.sv */
`timescale 1ns/1ns
module aol_alarm_lines_checker (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        scan_start_i,
  input wire logic [3:0]  alarm_line_o,
  input wire logic        evt_valid_o,
  input wire logic [2:0]  evt_flags_o,
  input wire logic        rec_valid_o,
  input wire logic [2:0]  rec_flags_o,
  input wire logic        mem_clear_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic done;
  assign done = psel_i && penable_i && pready_o;
  pready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready held two cycles");
  wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("wait state wrong");
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  unmapped_err_a: assert property (done && paddr_i > aol_pkg::OFS_STATUS |-> pslverr_o) else $error("no error");
  clear_rd_zero_a: assert property (done && !pwrite_i && paddr_i == aol_pkg::OFS_CLEAR |-> prdata_o == 32'h0)
    else $error("clear register read not zero");
  scan_clear_a: assert property (scan_start_i |=> mem_clear_o && (alarm_line_o == 4'h0 || alarm_line_o == 4'hF))
    else $error("scan start did not clear");
  memclr_cause_a: assert property (mem_clear_o |-> $past(scan_start_i)) else $error("stray memory clear");
  factory_rst_a: assert property (done && pwrite_i && paddr_i == aol_pkg::OFS_CTRL && pwdata_i[aol_pkg::CTRL_FRST]
    |=> alarm_line_o == 4'hF) else $error("factory reset left a line active");
  rec_in_evt_a: assert property (rec_valid_o |-> evt_valid_o && rec_flags_o == evt_flags_o)
    else $error("record without event");
  evt_flags_a: assert property (evt_valid_o |-> evt_flags_o != 3'h0) else $error("event without flag");
endmodule

/* bench/aol_lamp_model.sv */
`timescale 1ns/1ns
module aol_lamp_model (
  input  wire logic [aol_pkg::NUM_LINES-1:0] line_i,
  input  wire logic                          act_high_i,
  output logic      [aol_pkg::NUM_LINES-1:0] lit_o
);
  // The lamp only knows the wire level, so it is told the polarity the system was set to
  assign lit_o = act_high_i ? line_i : ~line_i;
endmodule

/* bench/aol_alarm_lines_test.sv */
`timescale 1ns/1ns
bind aol_alarm_lines aol_alarm_lines_checker u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .scan_start_i(scan_start_i), .alarm_line_o(alarm_line_o),
  .evt_valid_o(evt_valid_o), .evt_flags_o(evt_flags_o), .rec_valid_o(rec_valid_o), .rec_flags_o(rec_flags_o),
  .mem_clear_o(mem_clear_o));
module aol_alarm_lines_test;
  logic        clock_i, rst_b_i, psel, penable, pwrite, scan_start, scan_active, pol;
  logic        pready, pslverr, evt_v, rec_v, mem_clr, err, evt_seen, rec_seen;
  logic [7:0]  paddr, dio_lo, ext;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  evt_f, rec_f, rec_last;
  logic [3:0]  line, lit;
  logic [25:0] tot;
  int          err_total, n_checks, cyc;

  aol_alarm_lines DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .ext_alarm_i(ext), .dio_lo_i(dio_lo), .dio_hi_i(8'h00), .tot_count_i(tot),
    .scan_start_i(scan_start), .scan_active_i(scan_active), .alarm_line_o(line), .evt_valid_o(evt_v),
    .evt_flags_o(evt_f), .rec_valid_o(rec_v), .rec_flags_o(rec_f), .mem_clear_o(mem_clr));
  aol_lamp_model u_lamp (.line_i(line), .act_high_i(pol), .lit_o(lit));

  initial
  begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (evt_v === 1'b1)
      evt_seen <= 1'b1;
    if (rec_v === 1'b1)
    begin
      rec_seen <= 1'b1;
      rec_last <= rec_f;
    end
    if (cyc == 5000)
    begin
      err_total++;
      end_sim;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    @(posedge clock_i);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 20)
      err_total++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wt(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask

  task pulse(input logic [7:0] v);
    @(posedge clock_i);
    ext <= v;
    @(posedge clock_i);
    ext <= 8'h00;
    wt(1);
  endtask

  task t_reset;
    chk(line, 4'hF);
    apb(1'b0, aol_pkg::OFS_CTRL, 32'h0);
    chk(rd, {30'h0, aol_pkg::RST_POL, aol_pkg::RST_LATCH});
    apb(1'b0, aol_pkg::OFS_PAT_LO, 32'h0);
    chk(rd, {16'h0, aol_pkg::RST_CARE, aol_pkg::RST_VAL});
    apb(1'b0, 8'h20, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("t_reset done");
  endtask

  task t_latch;
    apb(1'b1, aol_pkg::OFS_ROUTE, 32'h0000000A);
    pulse(8'h01);
    chk(lit, 4'h4);
    apb(1'b1, aol_pkg::OFS_CLEAR, 32'h1);
    wt(1);
    chk(lit, 4'h4);
    @(posedge clock_i);
    scan_active <= 1'b1;
    apb(1'b1, aol_pkg::OFS_CLEAR, 32'h4);
    wt(1);
    chk(lit, 4'h0);
    pulse(8'h02);
    chk(lit, 4'h4);
    apb(1'b1, aol_pkg::OFS_CLEAR, 32'h10);
    wt(1);
    chk(lit, 4'h0);
    pulse(8'h03);
    @(posedge clock_i);
    scan_start <= 1'b1;
    @(posedge clock_i);
    scan_start <= 1'b0;
    @(negedge clock_i);
    chk(mem_clr, 1'b1);
    chk(lit, 4'h0);
    $display("t_latch done");
  endtask

  task t_track;
    apb(1'b1, aol_pkg::OFS_CTRL, 32'h0);
    @(posedge clock_i);
    ext <= 8'h01;
    scan_active <= 1'b0;
    wt(1);
    chk(lit, 4'h4);
    // Clear is momentary here: the source is still out, so the line comes straight back
    apb(1'b1, aol_pkg::OFS_CLEAR, 32'h10);
    wt(1);
    chk(lit, 4'h4);
    pol <= 1'b1;
    apb(1'b1, aol_pkg::OFS_CTRL, 32'h2);
    wt(0);
    chk(line, 4'h4);
    @(posedge clock_i);
    ext <= 8'h00;
    wt(1);
    chk(line, 4'h0);
    apb(1'b1, aol_pkg::OFS_CTRL, 32'h100);
    pol <= 1'b0;
    wt(0);
    chk(line, 4'hF);
    apb(1'b0, aol_pkg::OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    $display("t_track done");
  endtask

  task t_pattern;
    apb(1'b1, aol_pkg::OFS_PAT_LO, 32'h0000F080);
    apb(1'b1, aol_pkg::OFS_MFCFG, 32'h00000101);
    wt(4);
    chk(lit, 4'h0);
    evt_seen = 1'b0;
    @(posedge clock_i);
    dio_lo <= 8'h8D;
    wt(4);
    chk(lit, 4'h2);
    chk(evt_seen, 1'b1);
    chk(rec_seen, 1'b0);
    apb(1'b1, aol_pkg::OFS_MFCFG, 32'h00001101);
    wt(3);
    chk(lit, 4'h0);
    @(posedge clock_i);
    dio_lo <= 8'h92;
    wt(4);
    chk(lit, 4'h2);
    apb(1'b1, aol_pkg::OFS_MFCFG, 32'h00001001);
    wt(3);
    chk(lit, 4'h0);
    $display("t_pattern done");
  endtask

  task t_total;
    @(posedge clock_i);
    tot <= 26'd9;
    scan_active <= 1'b1;
    apb(1'b1, aol_pkg::OFS_TOT_LIM, 32'd10);
    apb(1'b1, aol_pkg::OFS_MFCFG, 32'h00000430);
    wt(3);
    chk(lit, 4'h0);
    @(posedge clock_i);
    tot <= 26'd10;
    wt(3);
    chk(lit, 4'h8);
    chk(rec_seen, 1'b1);
    chk(rec_last, 3'b100);
    $display("t_total done");
  endtask

  task end_sim;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    rst_b_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 8'h00;
    dio_lo = 8'h92;
    tot = 26'h0;
    scan_start = 1'b0;
    scan_active = 1'b0;
    pol = 1'b0;
    evt_seen = 1'b0;
    rec_seen = 1'b0;
    rec_last = 3'h0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(negedge clock_i);
    t_reset;
    t_latch;
    t_track;
    t_pattern;
    t_total;
    end_sim;
  end
endmodule
